// ### tmr_mode_ctrl.sv
// Mode control and 8-bit counter of a period timer with external reset/trigger.
// Assumes the clock is the prescaled timer clock and the trigger is asynchronous.
`timescale 1ns/1ps
`include "tmr_mode_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Counter increments each clock; returns to zero clock after matching period.
// - In debug mode the external level is frozen: no edges arrive, the held level still acts.
// - Mode 00000 counts while enabled, pauses when not, no external reset.
// - Mode 00001 counts while enabled and external signal high.
// - Modes 00011-00101 free-run, reset on any, rising, falling edge.
// - Modes 00110/00111 hold reset while signal low/high, then resume.
// - Mode 01000 starts on enable alone and runs one period.
// - Modes 01001-01011 start on enable plus rising, falling, any edge.
// - Modes 01100-01111 start on edge, reset on like edge or level.
// - Edge-started modes need a new edge after re-enabling.
// - One-shot modes clear enable and stop at zero after period match.
// - Monostable modes 10001-10011 start on rising, falling, any edge.
// - Monostable modes 10001-10011 stop at zero after period match, enable stays set.
// - Modes 10110/10111 start on high/low level, reset on opposite level.
module tmr_mode_ctrl
   import tmr_mode_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Software controls and debug
   input wire tmr_ctrl_t ctrl_i,
   input wire logic debug_i,
   // External trigger/reset
   input wire logic ext_trigger_reset_in_i,
   // Status
   output tmr_stat_t stat_o
);

   logic sync1_q;
   logic sync2_q;
   logic ers_prev_q;
   logic [7:0] count_q;
   logic [7:0] count_d;
   tmr_state_t state_q;
   tmr_state_t state_d;
   logic en_clr_q;
   logic en_clr_d;
   logic match_q;
   logic ers;
   logic rise;
   logic fall;
   logic [1:0] mode_class_bits;
   logic edge_start;
   logic ext_rst;
   logic level_start;
   logic enabled;
   logic level_oneshot;

   // Edge-start selection from the two low mode bits
   function automatic logic edge_sel(input logic [2:0] m, input logic r, input logic f);
      logic s;
      s = 1'b0;
      unique case (m[1:0])
         2'h1: s = r;
         2'h2: s = f;
         2'h3: s = r | f;
         default: s = 1'b0;
      endcase
      return s;
   endfunction

   // Modes that start on the enable bit alone, with no external trigger
   function automatic logic sw_start(input logic [4:0] m);
      return (m[4:3] == `MODE_CLASS_FREE) || (m == `MODE_OS_SW);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchroniser of the external signal, then an edge history flop
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         ers_prev_q <= 1'b0;
      end else begin
         sync1_q <= ext_trigger_reset_in_i;
         sync2_q <= sync1_q;
         ers_prev_q <= debug_i ? ers_prev_q : sync2_q;
      end
   end

   // Debug freezes the seen level so no edges or level changes arrive
   assign ers = debug_i ? ers_prev_q : sync2_q;
   assign rise = ers & ~ers_prev_q & ~debug_i;
   assign fall = ~ers & ers_prev_q & ~debug_i;
   assign mode_class_bits = ctrl_i.mode[4:3];
   // Level-started one-shot modes of the monostable class
   assign level_oneshot = (mode_class_bits == `MODE_CLASS_MONO) && (ctrl_i.mode[2:1] == 2'h3);
   // Enable bit as seen by the timer, cleared by a pending one-shot finish
   assign enabled = ctrl_i.enable & ~en_clr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Start, reset and level decoding per mode
   always_comb begin
      edge_start = 1'b0;
      ext_rst = 1'b0;
      level_start = 1'b0;
      unique case (ctrl_i.mode)
         `MODE_RST_ANY: ext_rst = rise | fall;
         `MODE_RST_RISE: ext_rst = rise;
         `MODE_RST_FALL: ext_rst = fall;
         `MODE_RST_LOW: ext_rst = ~ers;
         `MODE_RST_HIGH: ext_rst = ers;
         `MODE_OS_RISE, `MODE_OS_FALL, `MODE_OS_ANY,
         `MODE_MONO_RISE, `MODE_MONO_FALL, `MODE_MONO_ANY:
            edge_start = edge_sel(ctrl_i.mode[2:0], rise, fall);
         `MODE_OS_RISE_RR, `MODE_OS_RISE_RL: begin
            edge_start = rise;
            ext_rst = ctrl_i.mode[1] ? ~ers : rise;
         end
         `MODE_OS_FALL_RF, `MODE_OS_FALL_RH: begin
            edge_start = fall;
            ext_rst = ctrl_i.mode[1] ? ers : fall;
         end
         `MODE_LOS_HIGH: begin
            level_start = ers;
            ext_rst = ~ers;
         end
         `MODE_LOS_LOW: begin
            level_start = ~ers;
            ext_rst = ers;
         end
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run state: idle (disabled), armed (waiting trigger), run
   always_comb begin
      state_d = state_q;
      if (!enabled) begin
         state_d = ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (sw_start(ctrl_i.mode)) begin
                  state_d = ST_RUN;
               end else begin
                  state_d = ST_ARMED;
               end
            end
            ST_ARMED: begin
               // A mode switched while armed must not leave the timer stuck
               if (edge_start || level_start || sw_start(ctrl_i.mode)) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (match_q && mode_class_bits == `MODE_CLASS_MONO && !level_oneshot) begin
                  state_d = ST_ARMED;
               end else if (match_q && mode_class_bits != `MODE_CLASS_FREE) begin
                  state_d = ST_IDLE;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter with period match and external reset
   always_comb begin
      count_d = count_q;
      if (state_q == ST_RUN && enabled) begin
         if (ext_rst) begin
            count_d = `COUNT_RST;
         end else if (ctrl_i.mode == `MODE_HW_GATE_HI && !ers) begin
            count_d = count_q;
         end else if (ctrl_i.mode == `MODE_HW_GATE_LO && ers) begin
            count_d = count_q;
         end else if (match_q) begin
            // Wrap waits for an open gate, as a closed gate holds the timer clock
            count_d = `COUNT_RST;
         end else begin
            count_d = count_q + 8'h01;
         end
      end else if (state_q == ST_ARMED && ext_rst && mode_class_bits != `MODE_CLASS_MONO) begin
         count_d = `COUNT_RST;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         count_q <= `COUNT_RST;
         match_q <= 1'b0;
      end else begin
         count_q <= count_d;
         match_q <= (count_d == ctrl_i.period_value) && (state_d == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One-shot completion clears the enable and wins over software setting it in the same cycle
   assign en_clr_d = state_q == ST_RUN && enabled && match_q
                     && (mode_class_bits == `MODE_CLASS_ONESHOT || level_oneshot);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         en_clr_q <= 1'b0;
      end else if (en_clr_d) begin
         en_clr_q <= 1'b1;
      end else if (ctrl_i.enable_set || !ctrl_i.enable) begin
         en_clr_q <= 1'b0;
      end
   end

   // Status outputs from flops; enable_clear asks software to drop the bit
   assign stat_o.count_value = count_q;
   assign stat_o.running = (state_q == ST_RUN);
   assign stat_o.enable_clear = en_clr_q;
   assign stat_o.period_match = match_q;

endmodule

// ### tmr_mode_cfg.svh
// Constants for the mode-controlled period timer: mode codes and timing counts.
// Assumes inclusion by the timer module only.
`ifndef TMR_MODE_CFG_SVH
`define TMR_MODE_CFG_SVH
// Mode class field values (upper two mode bits)
`define MODE_CLASS_FREE 2'h0
`define MODE_CLASS_ONESHOT 2'h1
`define MODE_CLASS_MONO 2'h2
// Mode field values
`define MODE_SW_GATE 5'h00
`define MODE_HW_GATE_HI 5'h01
`define MODE_HW_GATE_LO 5'h02
`define MODE_RST_ANY 5'h03
`define MODE_RST_RISE 5'h04
`define MODE_RST_FALL 5'h05
`define MODE_RST_LOW 5'h06
`define MODE_RST_HIGH 5'h07
`define MODE_OS_SW 5'h08
`define MODE_OS_RISE 5'h09
`define MODE_OS_FALL 5'h0A
`define MODE_OS_ANY 5'h0B
`define MODE_OS_RISE_RR 5'h0C
`define MODE_OS_FALL_RF 5'h0D
`define MODE_OS_RISE_RL 5'h0E
`define MODE_OS_FALL_RH 5'h0F
`define MODE_MONO_RISE 5'h11
`define MODE_MONO_FALL 5'h12
`define MODE_MONO_ANY 5'h13
`define MODE_LOS_HIGH 5'h16
`define MODE_LOS_LOW 5'h17
// Reset values
`define COUNT_RST 8'h00
// Trigger source timing, in timer clock periods
`define EDGE_SPACING_CLKS 6
`define LEVEL_HOLD_CLKS 3
`endif

// ### tmr_mode_pkg.sv
// Types for the mode-controlled period timer.
// Assumes tmr_mode_cfg.svh is on the include path.
package tmr_mode_pkg;
   // Timer controls from the software side
   typedef struct packed {
      logic [4:0] mode;
      logic enable;
      logic enable_set;
      logic [7:0] period_value;
   } tmr_ctrl_t;
   // Timer status back to the software side
   typedef struct packed {
      logic [7:0] count_value;
      logic running;
      logic enable_clear;
      logic period_match;
   } tmr_stat_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} tmr_state_t;
endpackage

// ### tmr_trig_src_model.sv
// Model of the external trigger/reset source.
// Assumes the bench asks for a level and this model spaces the pin changes.
`timescale 1ns/1ps
module tmr_trig_src_model (
   // Clock
   input wire logic sys_clk_i,
   // Requested level and driven pin
   input wire logic want_i,
   output logic ext_o
);
   logic [3:0] gap_q = 4'hF;
   logic lvl_q = 1'b0;
   assign ext_o = lvl_q;
   // Follow the request only once the last level has stood six clocks
   always @(posedge sys_clk_i) begin
      if (want_i != lvl_q && gap_q >= 4'h6) begin
         lvl_q <= want_i;
         gap_q <= 4'h1;
      end else if (gap_q != 4'hF) begin
         gap_q <= gap_q + 4'h1;
      end
   end
endmodule

// ### tmr_mode_ctrl_asserts.sv
// Port assertions for the timer mode control.
// Assumes one clock and an active-high synchronous reset.
`timescale 1ns/1ps
module tmr_mode_ctrl_asserts
   import tmr_mode_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire tmr_ctrl_t ctrl_i,
   input wire logic debug_i,
   input wire logic ext_trigger_reset_in_i,
   input wire tmr_stat_t stat_o
);
   // Short views of the watched fields
   wire logic [4:0] m = ctrl_i.mode;
   wire logic en = ctrl_i.enable;
   wire logic [7:0] cnt = stat_o.count_value;
   wire logic hi = ext_trigger_reset_in_i & ~debug_i;
   wire logic lo = ~ext_trigger_reset_in_i & ~debug_i;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   AST_WRAP: assert property (
      m == 5'h00 && en && !stat_o.enable_clear && stat_o.period_match |=> cnt == 8'h00)
      else $error("no wrap");
   AST_START: assert property (
      m == 5'h00 && en && !stat_o.running && !stat_o.enable_clear |=> stat_o.running)
      else $error("no start");
   AST_PAUSE: assert property (
      (m == 5'h00 && !en) [*2] |=> $stable(cnt)) else $error("no pause");
   AST_GATE_HI: assert property (
      (m == 5'h01 && lo) [*5] |=> $stable(cnt)) else $error("gate high");
   AST_GATE_LO: assert property (
      (m == 5'h02 && hi) [*5] |=> $stable(cnt)) else $error("gate low");
   AST_LVL_RST: assert property (
      ((m == 5'h06 && lo || m == 5'h07 && hi) && en && !stat_o.enable_clear) [*5]
      |-> cnt == 8'h00)
      else $error("level reset");
   AST_OS_END: assert property (
      stat_o.period_match && m == 5'h08 && en && !ctrl_i.enable_set
      |=> cnt == 8'h00 && stat_o.enable_clear) else $error("one-shot end");
   AST_MONO_END: assert property (
      stat_o.period_match && m == 5'h11 && en |=> cnt == 8'h00 && !stat_o.enable_clear)
      else $error("mono end");
endmodule
bind tmr_mode_ctrl tmr_mode_ctrl_asserts i_tmr_mode_ctrl_asserts (.sys_clk_i(sys_clk_i),
   .rst_i(rst_i), .ctrl_i(ctrl_i), .debug_i(debug_i),
   .ext_trigger_reset_in_i(ext_trigger_reset_in_i), .stat_o(stat_o));

// ### tmr_mode_ctrl_tb_top.sv
// Self-checking bench for the timer mode control.
// Assumes the trigger model and the bound checker are compiled first.
`timescale 1ns/1ps
module tmr_mode_ctrl_tb_top;
   import tmr_mode_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic debug_i = 1'b0;
   logic want = 1'b0;
   logic ext;
   tmr_ctrl_t ctrl = '0;
   tmr_stat_t stat;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [7:0] per;
   logic [4:0] smode [6] = '{5'h09, 5'h0A, 5'h0B, 5'h11, 5'h12, 5'h13};
   logic [4:0] gmode [4] = '{5'h01, 5'h02, 5'h06, 5'h07};
   logic [4:0] lmode [3] = '{5'h0C, 5'h0E, 5'h16};
   logic [7:0] c0;
   logic [7:0] seen8;
   always #10 sys_clk_i = ~sys_clk_i;
   tmr_mode_ctrl i_tmr_mode_ctrl (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ctrl_i(ctrl),
      .debug_i(debug_i), .ext_trigger_reset_in_i(ext), .stat_o(stat));
   tmr_trig_src_model i_tmr_trig_src_model (.sys_clk_i(sys_clk_i), .want_i(want),
      .ext_o(ext));
   ////////////////////////////////////////////////////////////////////////////
   // Helpers for waiting, driving and comparing
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic pulse_on;
      ctrl.enable <= 1'b1;
      ctrl.enable_set <= 1'b1;
      cyc(1);
      ctrl.enable_set <= 1'b0;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Idle level before the start edge, and whether an edge resets
   function automatic logic idle(input logic [4:0] m);
      if (m[1:0] == 2'h3) return 1'($urandom);
      return m[1];
   endfunction
   function automatic logic hit(input logic [4:0] m, input logic r);
      return !debug_i && (m == 5'h03 || (m == 5'h04 && r) || (m == 5'h05 && !r));
   endfunction
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      cyc(3000);
      n_mismatch++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      per = 8'($urandom(48828));
      cyc(12);
      rst_i <= 1'b0;
      per = 8'($urandom_range(3, 9));
      ctrl.period_value <= per;
      ctrl.enable <= 1'b1;
      for (int i = 0; i < 9 && stat.running !== 1'b1; i++) cyc(1);
      for (int k = 1; k <= per + 1; k++) begin
         cyc(1);
         chk("count", stat.count_value, 8'(k % (per + 1)));
         chk("match", {7'h00, stat.period_match}, {7'h00, k == per});
      end
      ctrl.enable <= 1'b0;
      cyc(6);
      chk("pause", stat.count_value, 8'h01);
      $display("software gate done");
      ctrl.mode <= 5'h08;
      pulse_on();
      for (int i = 0; i < 30 && stat.enable_clear !== 1'b1; i++) cyc(1);
      cyc(4);
      chk("oneshot", {stat.enable_clear, stat.count_value[6:0]}, 8'h80);
      $display("software one-shot done");
      foreach (smode[j]) begin
         ctrl.enable <= 1'b0;
         ctrl.mode <= smode[j];
         want <= idle(smode[j]);
         cyc(10);
         pulse_on();
         cyc(10);
         chk("armed", {7'h00, stat.running}, 8'h00);
         want <= ~want;
         for (int i = 0; i < 12 && stat.running !== 1'b1; i++) cyc(1);
         chk("start", {7'h00, stat.running}, 8'h01);
         // Let the period run out: one-shots drop the enable, monostables keep it
         cyc(per + 3);
         seen8 = {stat.enable_clear, stat.running, stat.count_value[5:0]};
         chk("stop", seen8, {~smode[j][4], 7'h00});
      end
      $display("edge start done");
      ctrl.period_value <= 8'hFF;
      for (int i = 0; i < 4; i++) begin
         ctrl.enable <= 1'b0;
         ctrl.mode <= (i == 3) ? 5'h03 : 5'(3 + i);
         debug_i <= (i == 3);
         want <= 1'b0;
         cyc(8);
         ctrl.enable <= 1'b1;
         cyc(30);
         want <= 1'b1;
         cyc(8);
         chk("up", 8'(stat.count_value < 8'h0C), 8'(hit(ctrl.mode, 1'b1)));
         cyc(20);
         want <= 1'b0;
         cyc(8);
         chk("dn", 8'(stat.count_value < 8'h0C), 8'(hit(ctrl.mode, 1'b0)));
      end
      debug_i <= 1'b0;
      $display("edge reset done");
      foreach (gmode[j]) begin
         ctrl.mode <= gmode[j];
         want <= (gmode[j] == 5'h02 || gmode[j] == 5'h07);
         cyc(12);
         c0 = stat.count_value;
         cyc(4);
         chk("held", stat.count_value, gmode[j][2] ? 8'h00 : c0);
         want <= ~want;
         cyc(12);
         chk("resume", 8'(stat.count_value != c0), 8'h01);
      end
      $display("gate and level done");
      // Edge start with like-edge or level reset, and level start
      foreach (lmode[j]) begin
         ctrl.enable <= 1'b0;
         ctrl.mode <= lmode[j];
         want <= 1'b0;
         cyc(10);
         pulse_on();
         cyc(10);
         chk("larmed", {7'h00, stat.running}, 8'h00);
         want <= 1'b1;
         cyc(20);
         chk("lstart", {7'h00, stat.running}, 8'h01);
         want <= 1'b0;
         cyc(8);
         chk("lreset", {7'h00, stat.count_value < 8'h06}, {7'h00, lmode[j] != 5'h0C});
      end
      $display("level start done");
      tally_and_finish();
   end
endmodule
